// ### logic/ict_timer.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - system reset returns counter, capture and match registers to defaults
// - counter-clear control bit also clears the free-running counter
// - nine interrupt outputs: six capture, two match, one wrap
// - capture and wrap interrupt outputs drive unconditionally; match outputs are masked by their enable bits
// - disabled or sleep-requested but busy: clock request stays high
// - active and not sleep-requested: clock request always high
// - disabled or sleep-requested and idle: clock request drops low
// - filtered input changes only after three stable filter clock ticks
// - bypass chosen per input; one filter clock shared by all filtered inputs
// - bypass only synchronises; otherwise synchronise and filter
// - six capture registers, each tied to same-index pin and interrupt
// - selected edge loads counter into capture register and pulses its interrupt
// - capture registers read-only, overwritten each edge, no overrun guard
// - two 32-bit match registers each pulse own interrupt on equality
// - activate bit zero powers block down; one lets it run
// - run bit starts/stops without clearing; counter writable only while stopped; wraps
// - clear zeroes counter and self-clears after one cycle; leaves run bit alone, so counting resumes if run is set
// - 3-bit select picks counting rate from divided clock enables
// - each match interrupt gated by its own enable bit
module ict_timer
    import ict_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  rst_b_i,
    input  wire logic [NUM_CLK_EN-1:0] clk_en_div_i,
    input  wire logic [NUM_CAP-1:0]    capture_input_i,
    input  wire logic                  sleep_request_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    input  wire logic [3:0]            reg_be_i,
    input  wire logic [31:0]           reg_wdata_i,
    output logic      [31:0]           reg_rdata_o,
    output logic      [NUM_CAP-1:0]    capture_irq_o,
    output logic      [NUM_MATCH-1:0]  match_irq_o,
    output logic                       wrap_irq_o,
    output logic                       clock_request_o
);
    logic                 active_reg;
    logic                 run_reg;
    logic                 clear_reg;
    logic [2:0]           counter_clock_select_reg;
    logic [NUM_MATCH-1:0] match_en_reg;
    logic [31:0]          capctl_lo_reg;
    logic [31:0]          capctl_hi_reg;
    logic [31:0]          count_reg;
    logic [31:0]          count_next;
    logic [31:0]          cap_reg   [NUM_CAP];
    logic [31:0]          match_reg [NUM_MATCH];
    logic [31:0]          rd_word;
    logic [NUM_CAP-1:0]   rise;
    logic [NUM_CAP-1:0]   fall;
    logic [NUM_CAP-1:0]   busy;
    logic [NUM_CAP-1:0]   cap_evt;
    logic [63:0]          capctl_all;
    logic                 run_ok;
    logic                 tick;
    logic                 filt_tick;
    logic                 wr_ctl;
    logic                 wr_count;
    logic                 low_power;
    logic                 idle;

    // byte-lane merge of a write onto the current value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) res[8*b +: 8] = wd[8*b +: 8];
        end
        return res;
    endfunction : merge

    assign wr_ctl     = reg_wr_i && reg_addr_i == OFF_CTL;
    assign wr_count   = reg_wr_i && reg_addr_i == OFF_COUNT && !run_reg;
    assign capctl_all = {capctl_hi_reg, capctl_lo_reg};
    // a deactivated or sleeping block neither counts nor captures
    assign run_ok     = active_reg & ~sleep_request_i;
    assign tick       = run_ok & run_reg & ~clear_reg & clk_en_div_i[counter_clock_select_reg];
    // the filter clock comes from input 0's select field only, shared by all
    assign filt_tick  = clk_en_div_i[capctl_lo_reg[CAPF_FSEL_LSB +: 3]];
    assign count_next = count_reg + 32'h1;                               // wraps to zero

    // timer_control; clear is set by software and dropped by hardware
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_reg   <= CTL_RESET[CTL_ACTIVATE];
            run_reg      <= CTL_RESET[CTL_RUN];
            clear_reg    <= CTL_RESET[CTL_CLEAR];
            counter_clock_select_reg     <= CTL_RESET[CTL_COUNTER_CLOCK_SELECT_LSB +: 3];
            match_en_reg <= CTL_RESET[CTL_MEN_LSB +: NUM_MATCH];
        end else begin
            if (wr_ctl && reg_be_i[0]) begin
                active_reg <= reg_wdata_i[CTL_ACTIVATE];
                run_reg    <= reg_wdata_i[CTL_RUN];
                counter_clock_select_reg   <= reg_wdata_i[CTL_COUNTER_CLOCK_SELECT_LSB +: 3];
            end
            if (wr_ctl && reg_be_i[1]) match_en_reg <= reg_wdata_i[CTL_MEN_LSB +: NUM_MATCH];
            // a new request in the same cycle wins over the self-clear
            if (wr_ctl && reg_be_i[0] && reg_wdata_i[CTL_CLEAR]) clear_reg <= 1'b1;
            else if (clear_reg)                                   clear_reg <= 1'b0;
        end
    end

    // capture control, reserved bits held at zero
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            capctl_lo_reg <= CAPCTL_RESET;
            capctl_hi_reg <= CAPCTL_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == OFF_CAPCTL_LO)
                capctl_lo_reg <= merge(capctl_lo_reg, reg_wdata_i, reg_be_i) & CAPCTL_LO_MASK;
            if (reg_addr_i == OFF_CAPCTL_HI)
                capctl_hi_reg <= merge(capctl_hi_reg, reg_wdata_i, reg_be_i) & CAPCTL_HI_MASK;
        end
    end

    // free-running counter: clear beats a write, a write beats a tick
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i)      count_reg <= COUNT_RESET;
        else if (clear_reg) count_reg <= COUNT_RESET;
        else if (wr_count)  count_reg <= merge(count_reg, reg_wdata_i, reg_be_i);
        else if (tick)      count_reg <= count_next;
    end

    // match registers
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int m = 0; m < NUM_MATCH; m++) match_reg[m] <= MATCH_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == OFF_MATCH0) match_reg[0] <= merge(match_reg[0], reg_wdata_i, reg_be_i);
            if (reg_addr_i == OFF_MATCH1) match_reg[1] <= merge(match_reg[1], reg_wdata_i, reg_be_i);
        end
    end

    // wrap and match pulses line up with the counter step that causes them
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wrap_irq_o  <= 1'b0;
            match_irq_o <= '0;
        end else begin
            wrap_irq_o <= tick && count_reg == 32'hffffffff;
            for (int m = 0; m < NUM_MATCH; m++)
                match_irq_o[m] <= tick && match_en_reg[m] && count_next == match_reg[m];
        end
    end

    // one conditioner per capture pin
    for (genvar g = 0; g < NUM_CAP; g++) begin : g_cond
        ict_input_cond u_cond (
            .clock_i     (clock_i),
            .rst_b_i     (rst_b_i),
            .pin_i       (capture_input_i[g]),
            .bypass_i    (capctl_all[8*g + CAPF_BYPASS]),
            .filt_tick_i (filt_tick),
            .rise_o      (rise[g]),
            .fall_o      (fall[g]),
            .busy_o      (busy[g])
        );
    end

    // edge selection; code 11 disables the input
    always_comb begin
        for (int i = 0; i < NUM_CAP; i++) begin
            case (capctl_all[8*i + CAPF_EDGE_LSB +: 2])
                EDGE_FALL: cap_evt[i] = run_ok & fall[i];
                EDGE_RISE: cap_evt[i] = run_ok & rise[i];
                EDGE_BOTH: cap_evt[i] = run_ok & (rise[i] | fall[i]);
                default:   cap_evt[i] = 1'b0;
            endcase
        end
    end

    // captures overwrite without any overrun guard
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NUM_CAP; i++) cap_reg[i] <= CAP_RESET;
            capture_irq_o <= '0;
        end else begin
            for (int i = 0; i < NUM_CAP; i++)
                if (cap_evt[i]) cap_reg[i] <= count_reg;
            capture_irq_o <= cap_evt;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        case (reg_addr_i)
            OFF_CTL: begin
                rd_word = 32'h0;
                rd_word[CTL_ACTIVATE]              = active_reg;
                rd_word[CTL_RUN]                   = run_reg;
                rd_word[CTL_CLEAR]                 = clear_reg;
                rd_word[CTL_COUNTER_CLOCK_SELECT_LSB +: 3]         = counter_clock_select_reg;
                rd_word[CTL_MEN_LSB +: NUM_MATCH]  = match_en_reg;
            end
            OFF_CAPCTL_LO: rd_word = capctl_lo_reg;
            OFF_CAPCTL_HI: rd_word = capctl_hi_reg;
            OFF_COUNT:     rd_word = count_reg;
            OFF_CAP0:      rd_word = cap_reg[0];
            OFF_CAP1:      rd_word = cap_reg[1];
            OFF_CAP2:      rd_word = cap_reg[2];
            OFF_CAP3:      rd_word = cap_reg[3];
            OFF_CAP4:      rd_word = cap_reg[4];
            OFF_CAP5:      rd_word = cap_reg[5];
            OFF_MATCH0:    rd_word = match_reg[0];
            OFF_MATCH1:    rd_word = match_reg[1];
            default:       rd_word = 32'h0;
        endcase
    end

    // whole word registered so one access sees a consistent value
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i)      reg_rdata_o <= 32'h0;
        else if (reg_rd_i) reg_rdata_o <= rd_word;
        else               reg_rdata_o <= 32'h0;
    end

    // clock request drops only once a disabled or sleeping block is quiet
    assign low_power = ~active_reg | sleep_request_i;
    assign idle      = ~|busy & ~clear_reg & ~|cap_evt;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) clock_request_o <= CLKREQ_RESET;
        else          clock_request_o <= ~(low_power & idle);
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    property p_clear_zero;
        clear_reg |=> count_reg == 32'h0 && $stable(run_reg);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear left counter nonzero");

    property p_clear_self;
        clear_reg && !wr_ctl |=> !clear_reg;
    endproperty
    a_clear_self: assert property (p_clear_self) else $error("clear bit stuck");

    property p_busy_req;
        low_power && !idle |=> clock_request_o;
    endproperty
    a_busy_req: assert property (p_busy_req) else $error("clock request dropped while busy");

    property p_normal_req;
        !low_power |=> clock_request_o;
    endproperty
    a_normal_req: assert property (p_normal_req) else $error("clock request low in normal run");

    property p_sleep_req;
        low_power && idle |=> !clock_request_o;
    endproperty
    a_sleep_req: assert property (p_sleep_req) else $error("clock request high while idle");

    property p_capture_load;
        cap_evt[0] |=> cap_reg[0] == $past(count_reg) && capture_irq_o[0];
    endproperty
    a_capture_load: assert property (p_capture_load) else $error("capture 0 missed counter");

    property p_capture_only_edge;
        $changed(cap_reg[5]) |-> $past(cap_evt[5]);
    endproperty
    a_capture_only_edge: assert property (p_capture_only_edge) else $error("capture 5 moved without edge");

    property p_match;
        match_irq_o[1] |-> count_reg == match_reg[1] && $past(match_en_reg[1]);
    endproperty
    a_match: assert property (p_match) else $error("match 1 pulse without equality");

    property p_wrap_pulse;
        wrap_irq_o |-> count_reg == 32'h0 ##1 !wrap_irq_o;
    endproperty
    a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap pulse wrong");

    property p_count_rate;
        $changed(count_reg) && !$past(clear_reg) && !$past(wr_count) |-> $past(clk_en_div_i[counter_clock_select_reg]);
    endproperty
    a_count_rate: assert property (p_count_rate) else $error("counter stepped off its enable");

    property p_inactive_hold;
        !active_reg && !clear_reg && !wr_count |=> $stable(count_reg);
    endproperty
    a_inactive_hold: assert property (p_inactive_hold) else $error("counter ran while deactivated");

    c_capture: cover property (capture_irq_o[0]);
    c_wrap:    cover property (wrap_irq_o);
    c_match:   cover property (match_irq_o[0]);
    c_sleep:   cover property (clock_request_o ##1 !clock_request_o);
endmodule : ict_timer
`default_nettype wire

// ### inc/ict_pkg.sv
package ict_pkg;
    // block geometry
    localparam int          NUM_CAP        = 6;
    localparam int          NUM_MATCH      = 2;
    localparam int          NUM_CLK_EN     = 8;
    localparam logic [1:0]  FILT_TICKS     = 2'h3;   // stable ticks before the filtered level moves

    // register offsets (byte addresses)
    localparam logic [7:0]  OFF_CTL        = 8'h00;
    localparam logic [7:0]  OFF_CAPCTL_LO  = 8'h04;
    localparam logic [7:0]  OFF_CAPCTL_HI  = 8'h08;
    localparam logic [7:0]  OFF_COUNT      = 8'h0c;
    localparam logic [7:0]  OFF_CAP0       = 8'h10;
    localparam logic [7:0]  OFF_CAP1       = 8'h14;
    localparam logic [7:0]  OFF_CAP2       = 8'h18;
    localparam logic [7:0]  OFF_CAP3       = 8'h1c;
    localparam logic [7:0]  OFF_CAP4       = 8'h20;
    localparam logic [7:0]  OFF_CAP5       = 8'h24;
    localparam logic [7:0]  OFF_MATCH0     = 8'h28;
    localparam logic [7:0]  OFF_MATCH1     = 8'h2c;

    // timer_control fields
    localparam int          CTL_ACTIVATE   = 0;
    localparam int          CTL_RUN        = 1;
    localparam int          CTL_CLEAR      = 2;
    localparam int          CTL_COUNTER_CLOCK_SELECT_LSB   = 4;
    localparam int          CTL_MEN_LSB    = 8;

    // per-input byte of capture_control_low/high
    localparam int          CAPF_EDGE_LSB  = 0;
    localparam int          CAPF_BYPASS    = 2;
    localparam int          CAPF_FSEL_LSB  = 5;
    localparam logic [31:0] CAPCTL_LO_MASK = 32'he7e7e7e7;
    localparam logic [31:0] CAPCTL_HI_MASK = 32'h0000e7e7;

    // edge selection codes
    localparam logic [1:0]  EDGE_FALL      = 2'h0;
    localparam logic [1:0]  EDGE_RISE      = 2'h1;
    localparam logic [1:0]  EDGE_BOTH      = 2'h2;

    // reset values
    localparam logic [31:0] CTL_RESET      = 32'h00000000;
    localparam logic [31:0] CAPCTL_RESET   = 32'h00000000;
    localparam logic [31:0] COUNT_RESET    = 32'h00000000;
    localparam logic [31:0] CAP_RESET      = 32'h00000000;
    localparam logic [31:0] MATCH_RESET    = 32'h00000000;
    localparam logic        CLKREQ_RESET   = 1'b1;
endpackage : ict_pkg

// ### logic/ict_input_cond.sv
`timescale 1ns/1ns
`default_nettype none
module ict_input_cond
    import ict_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic pin_i,
    input  wire logic bypass_i,
    input  wire logic filt_tick_i,
    output logic      rise_o,
    output logic      fall_o,
    output logic      busy_o
);
    logic       sync1_reg;
    logic       sync2_reg;
    logic       level_reg;
    logic       prev_reg;
    logic [1:0] stable_cnt_reg;

    // two-flop synchroniser; the first stage feeds only the second
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    // bypass follows the synchronised pin; the filter waits for three stable ticks
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_reg      <= 1'b0;
            stable_cnt_reg <= 2'h0;
        end else if (bypass_i) begin
            level_reg      <= sync2_reg;
            stable_cnt_reg <= 2'h0;
        end else if (sync2_reg == level_reg) begin
            stable_cnt_reg <= 2'h0;       // a glitch back restarts the count
        end else if (filt_tick_i) begin
            if (stable_cnt_reg + 2'h1 == FILT_TICKS) begin
                level_reg      <= sync2_reg;
                stable_cnt_reg <= 2'h0;
            end else begin
                stable_cnt_reg <= stable_cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) prev_reg <= 1'b0;
        else          prev_reg <= level_reg;
    end

    assign rise_o = level_reg & ~prev_reg;
    assign fall_o = ~level_reg & prev_reg;
    // anything moving past the first synchroniser stage keeps the block awake
    assign busy_o = (sync2_reg != level_reg) | (level_reg != prev_reg) | (stable_cnt_reg != 2'h0);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    property p_filter_wait;
        !$past(bypass_i) && !bypass_i && $changed(level_reg) |-> $past(filt_tick_i) && $past(stable_cnt_reg) == 2'h2;
    endproperty
    a_filter_wait: assert property (p_filter_wait) else $error("filtered level moved early");

    property p_bypass_follow;
        bypass_i && $past(bypass_i) |-> level_reg == $past(sync2_reg);
    endproperty
    a_bypass_follow: assert property (p_bypass_follow) else $error("bypass level lags");
endmodule : ict_input_cond
`default_nettype wire

// ### testbench/ict_pin_agg.sv
`timescale 1ns/1ns
`default_nettype none
module ict_pin_agg
    import ict_pkg::*;
(
    input  wire logic                 clock_i,
    input  wire logic [NUM_CAP-1:0]   capture_irq_i,
    input  wire logic [NUM_MATCH-1:0] match_irq_i,
    input  wire logic                 wrap_irq_i,
    output logic      [NUM_CAP-1:0]   capture_input_o
);
    wire logic [8:0] src = {wrap_irq_i, match_irq_i, capture_irq_i};
    int              hits [9];

    // aggregator side: every high cycle latches one more source event, with no masking
    always @(posedge clock_i) begin
        for (int k = 0; k < 9; k++) begin
            if (src[k] === 1'b1) hits[k] = hits[k] + 1;
        end
    end

    initial capture_input_o = '0;

    // pins move just after the falling edge, never on the design's sampling edge
    task automatic set_pins(input logic [NUM_CAP-1:0] val);
        @(negedge clock_i);
        capture_input_o = val;
    endtask : set_pins

    task automatic clear_hits;
        for (int k = 0; k < 9; k++) hits[k] = 0;
    endtask : clear_hits
endmodule : ict_pin_agg
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin failures++; \
    $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module testbench;
    import ict_pkg::*;
    logic                 clock_i;
    logic                 rst_b_i;
    logic [7:0]           clk_en;
    logic                 sleep;
    logic [7:0]           addr;
    logic                 wr;
    logic                 rd;
    logic [31:0]          wdata;
    logic [3:0]           be;
    logic [31:0]          rdata;
    logic [NUM_CAP-1:0]   cap_irq;
    logic [NUM_CAP-1:0]   pins;
    logic [NUM_MATCH-1:0] m_irq;
    logic                 w_irq;
    logic                 creq;
    logic [31:0]          v;
    int                   failures;
    int                   checks;

    ict_timer uut (
        .clock_i         (clock_i),
        .rst_b_i         (rst_b_i),
        .clk_en_div_i    (clk_en),
        .capture_input_i (pins),
        .sleep_request_i (sleep),
        .reg_addr_i      (addr),
        .reg_wr_i        (wr),
        .reg_rd_i        (rd),
        .reg_be_i        (be),
        .reg_wdata_i     (wdata),
        .reg_rdata_o     (rdata),
        .capture_irq_o   (cap_irq),
        .match_irq_o     (m_irq),
        .wrap_irq_o      (w_irq),
        .clock_request_o (creq)
    );

    ict_pin_agg partner (
        .clock_i         (clock_i),
        .capture_irq_i   (cap_irq),
        .match_irq_i     (m_irq),
        .wrap_irq_i      (w_irq),
        .capture_input_o (pins)
    );

    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(negedge clock_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock_i);
        wr = 1'b0;
    endtask : wr_reg

    // always one full word per read, so a moving count is never torn
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(negedge clock_i);
        addr = a;
        rd = 1'b1;
        @(negedge clock_i);
        d = rdata;
        rd = 1'b0;
    endtask : rd_reg

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        rd_reg(a, v);
        `CHK(nm, ex, v)
    endtask : rd_chk

    // every offset plus the first unmapped one reads zero out of reset
    task automatic t_reset;
        for (int k = 0; k < 13; k++) rd_chk("reset_val", 8'(k * 4), 32'h0);
        `CHK("creq_idle", 1'b0, creq)
    endtask : t_reset

    task automatic t_regs;
        wr_reg(OFF_CTL, 32'hfffffffb);
        rd_chk("ctl_rw", OFF_CTL, 32'h00000373);
        wr_reg(OFF_CTL, 32'h0);
        wr_reg(OFF_CAPCTL_LO, 32'hffffffff);
        rd_chk("capctl_lo", OFF_CAPCTL_LO, CAPCTL_LO_MASK);
        wr_reg(OFF_CAPCTL_HI, 32'hffffffff);
        rd_chk("capctl_hi", OFF_CAPCTL_HI, CAPCTL_HI_MASK);
        wr_reg(OFF_CAP3, 32'h12345678);
        rd_chk("cap_ro", OFF_CAP3, 32'h0);
        // a single byte lane must leave the other three bytes alone
        wr_reg(OFF_MATCH0, 32'hffffffff);
        be = 4'h2;
        wr_reg(OFF_MATCH0, 32'h00001200);
        be = 4'hf;
        rd_chk("byte_lane", OFF_MATCH0, 32'hffff12ff);
    endtask : t_regs

    task automatic t_count;
        wr_reg(OFF_COUNT, 32'hfffffff0);
        clk_en = 8'h7f;
        wr_reg(OFF_CTL, 32'h73);
        tick(20);
        rd_chk("slow_sel", OFF_COUNT, 32'hfffffff0);
        wr_reg(OFF_COUNT, 32'h0);
        rd_chk("count_ro", OFF_COUNT, 32'hfffffff0);
        partner.clear_hits();
        clk_en = 8'hff;
        tick(40);
        wr_reg(OFF_CTL, 32'h1);
        `CHK("wrap_irq", 1, partner.hits[8])
        rd_reg(OFF_COUNT, v);
        rd_chk("hold", OFF_COUNT, v);
        wr_reg(OFF_CTL, 32'h5);
        tick(2);
        rd_chk("cleared", OFF_COUNT, 32'h0);
        wr_reg(OFF_CTL, 32'h7);
        tick(2);
        rd_chk("clear_self", OFF_CTL, 32'h3);
        wr_reg(OFF_CTL, 32'h1);
    endtask : t_count

    // every enable pair, including neither, against the two match points
    task automatic t_match;
        wr_reg(OFF_MATCH0, 32'h103);
        wr_reg(OFF_MATCH1, 32'h105);
        rd_chk("match_rw", OFF_MATCH1, 32'h105);
        for (int m = 0; m < 4; m++) begin
            wr_reg(OFF_COUNT, 32'h100);
            partner.clear_hits();
            wr_reg(OFF_CTL, 32'h3 | (m << 8));
            tick(10);
            wr_reg(OFF_CTL, 32'h1);
            `CHK("match0", m & 1, partner.hits[6])
            `CHK("match1", m >> 1, partner.hits[7])
        end
    endtask : t_match

    task automatic t_capture;
        int exp_hits [4] = '{1, 1, 2, 0};
        wr_reg(OFF_CAPCTL_LO, 32'h05050505);
        wr_reg(OFF_CAPCTL_HI, 32'h00000505);
        partner.clear_hits();
        for (int i = 0; i < NUM_CAP; i++) begin
            wr_reg(OFF_COUNT, 32'h1000 + i);
            partner.set_pins(pins | 6'(1 << i));
            tick(8);
            rd_chk("capture", OFF_CAP0 + 8'(4 * i), 32'h1000 + i);
            `CHK("cap_irq", 1, partner.hits[i])
        end
        // pin 0 makes one low pulse under each edge code; later values overwrite earlier
        for (int e = 0; e < 4; e++) begin
            wr_reg(OFF_CAPCTL_LO, 32'h05050504 | e);
            wr_reg(OFF_COUNT, 32'h3000 + e);
            partner.clear_hits();
            partner.set_pins(6'h3e);
            tick(8);
            partner.set_pins(6'h3f);
            tick(8);
            `CHK("edge_hits", exp_hits[e], partner.hits[0])
            rd_chk("overwrite", OFF_CAP0, (e == 3) ? 32'h3002 : 32'h3000 + e);
        end
    endtask : t_capture

    task automatic t_filter;
        wr_reg(OFF_CAPCTL_LO, 32'h0000e101);
        partner.set_pins(6'h00);
        tick(12);
        partner.clear_hits();
        partner.set_pins(6'h03);
        tick(1);
        partner.set_pins(6'h00);
        tick(12);
        `CHK("glitch", 0, partner.hits[0])
        partner.set_pins(6'h03);
        tick(12);
        `CHK("filtered0", 1, partner.hits[0])
        `CHK("filtered1", 1, partner.hits[1])
    endtask : t_filter

    task automatic t_clkreq;
        logic seen;
        seen = 1'b0;
        wr_reg(OFF_CTL, 32'h3);
        tick(3);
        `CHK("creq_run", 1'b1, creq)
        sleep = 1'b1;
        tick(3);
        `CHK("creq_sleep", 1'b0, creq)
        rd_reg(OFF_COUNT, v);
        partner.clear_hits();
        partner.set_pins(6'h02);
        for (int k = 0; k < 8; k++) begin
            tick(1);
            if (creq === 1'b1) seen = 1'b1;
        end
        `CHK("creq_busy", 1'b1, seen)
        tick(20);
        `CHK("creq_drop", 1'b0, creq)
        `CHK("sleep_drop", 0, partner.hits[1])
        rd_chk("sleep_hold", OFF_COUNT, v);
        sleep = 1'b0;
        // run bit left on: only the cleared activate bit may hold the count
        wr_reg(OFF_CTL, 32'h2);
        tick(3);
        `CHK("creq_off", 1'b0, creq)
        rd_reg(OFF_COUNT, v);
        tick(5);
        rd_chk("off_hold", OFF_COUNT, v);
    endtask : t_clkreq

    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    initial begin
        rst_b_i = 1'b0;
        clk_en = 8'hff;
        sleep = 1'b0;
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 32'h0;
        be = 4'hf;
        failures = 0;
        checks = 0;
        repeat (12) @(negedge clock_i);
        rst_b_i = 1'b1;
        tick(2);
        t_reset();
        t_regs();
        t_count();
        t_match();
        t_capture();
        t_filter();
        t_clkreq();
        close_out();
    end

    // the whole run needs well under a millisecond; this cuts a hang short
    initial begin
        #2000000;
        failures++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
